// ---- verilog/rcs_pkg.sv ----
// Package of shared constants and types for the rotate and subtract-with-borrow datapath
package rcs_pkg;

    // Data path width of the core
    localparam int unsigned DATA_W = 8;

    // Bit positions inside a data byte
    localparam int unsigned MSB_POS    = 7;   // Sign bit and carry entry of the rotate
    localparam int unsigned NIBBLE_MSB = 3;   // Top bit of the low nibble

    // Values after reset
    localparam logic [7:0] ACC_RST  = 8'h00;  // Accumulator
    localparam logic       FLAG_RST = 1'b0;   // Every status flag
    localparam logic [7:0] MEM_RST  = 8'h00;  // Memory write data

    // Cycles from a taken instruction to its visible result
    localparam int unsigned RESULT_LAT = 1;

    // Instructions handled by this block
    typedef enum logic [1:0] {
        RCS_OP_ROTATE_RIGHT_CARRY_TO_ACC,   // Rotate memory right through carry into the accumulator
        RCS_OP_SUBTRACT_WITH_BORROW_MEM,    // Accumulator minus memory operand, into accumulator
        RCS_OP_SUBTRACT_WITH_BORROW_IMM,    // Accumulator minus immediate byte, into accumulator
        RCS_OP_SUBTRACT_WITH_BORROW_TO_MEM  // Accumulator minus memory operand, into memory
    } rcs_op_t;

endpackage

// ---- verilog/rcs_alu.sv ----
// Rotate-right-through-carry and subtract-with-borrow datapath of an 8-bit core
// How it works
// RULE1: Rotate right; old carry to bit 7.
// RULE2: Rotate result goes to accumulator only.
// RULE3: Memory subtract: acc minus operand minus borrow.
// RULE4: Immediate subtract: acc minus immediate minus borrow.
// RULE5: To-memory subtract writes memory, not accumulator.
// RULE6: Carry clear if negative, else set.
// RULE7: Subtracts update all six arithmetic flags.
// RULE8: Zero, overflow, nibble borrow flag definitions.
`timescale 1ns/100ps

module rcs_alu (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Instruction issue
    input  wire logic            op_valid,
    input  wire rcs_pkg::rcs_op_t op_code,
    input  wire logic [7:0]      mem_operand,
    input  wire logic [7:0]      imm_operand,
    // Accumulator load from the rest of the core
    input  wire logic            acc_load_en,
    input  wire logic [7:0]      acc_load_data,
    // Carry load from the rest of the core
    input  wire logic            carry_load_en,
    input  wire logic            carry_load_value,
    // Accumulator and memory write-back
    output logic [7:0]           acc_ff,
    output logic                 mem_wr_en_ff,
    output logic [7:0]           mem_wr_data_ff,
    // Status flags
    output logic                 carry_flag_ff,
    output logic                 overflow_flag_ff,
    output logic                 zero_flag_ff,
    output logic                 aux_carry_flag_ff,
    output logic                 signed_carry_flag_ff,
    output logic                 carry_zero_flag_ff
);

    // Decoded instruction strobes
    logic       is_rotate;       // Rotate into accumulator
    logic       is_sub;          // Any subtract variant
    logic       is_sub_to_mem;   // Subtract writing memory
    logic [7:0] sub_operand;     // Memory byte or immediate byte
    logic       borrow_in;       // Inverted carry enters as borrow

    // Arithmetic results
    logic [8:0] diff_wide;       // Difference with borrow out in bit 8
    logic [4:0] nib_wide;        // Low nibble difference with borrow out
    logic [7:0] rot_result;      // Rotated byte
    logic [9:0] chk_diff_ext;    // Sign-extended difference, only read by the checks

    // Next values of the flags
    logic       nxt_carry;
    logic       nxt_overflow;
    logic       nxt_zero;
    logic       nxt_aux_carry;
    logic       nxt_signed_carry;
    logic       nxt_carry_zero;
    logic [7:0] nxt_acc;

    // Instruction decode
    always_comb begin
        is_rotate     = op_valid && (op_code == rcs_pkg::RCS_OP_ROTATE_RIGHT_CARRY_TO_ACC);
        is_sub_to_mem = op_valid && (op_code == rcs_pkg::RCS_OP_SUBTRACT_WITH_BORROW_TO_MEM);
        is_sub        = op_valid && (op_code != rcs_pkg::RCS_OP_ROTATE_RIGHT_CARRY_TO_ACC);
        // Immediate variant takes its byte from the instruction word
        sub_operand   = (op_code == rcs_pkg::RCS_OP_SUBTRACT_WITH_BORROW_IMM) ? imm_operand : mem_operand; // RULE4 RULE3
        borrow_in     = ~carry_flag_ff;
    end

    // Rotate and subtract arithmetic
    always_comb begin
        rot_result = {carry_flag_ff, mem_operand[7:1]}; // RULE1
        diff_wide  = {1'b0, acc_ff} - {1'b0, sub_operand} - {8'h00, borrow_in}; // RULE3 RULE4
        nib_wide   = {1'b0, acc_ff[3:0]} - {1'b0, sub_operand[3:0]} - {4'h0, borrow_in};
        // Two guard bits hold the true signed result, so overflow is seen without the flag logic
        chk_diff_ext = {{2{acc_ff[7]}}, acc_ff} - {{2{sub_operand[7]}}, sub_operand} - {9'h000, borrow_in};
    end

    // Flag results of a subtract
    always_comb begin
        // Borrow out means a negative difference, so carry clears
        nxt_carry        = ~diff_wide[8]; // RULE6
        nxt_zero         = (diff_wide[7:0] == 8'h00); // RULE8
        // Signed overflow: operands differ in sign and result sign follows the subtrahend
        nxt_overflow     = (acc_ff[7] ^ sub_operand[7]) & (acc_ff[7] ^ diff_wide[7]); // RULE8
        nxt_aux_carry    = ~nib_wide[4]; // RULE8
        // True sign of the difference, corrected for overflow
        nxt_signed_carry = nxt_overflow ^ diff_wide[7]; // RULE7
        // Zero chained across bytes of a multi-byte subtract
        nxt_carry_zero   = nxt_zero & carry_zero_flag_ff; // RULE7
    end

    // Next accumulator value
    always_comb begin
        nxt_acc = acc_ff;
        if (is_rotate) begin
            nxt_acc = rot_result; // RULE2
        end else if (is_sub && !is_sub_to_mem) begin
            nxt_acc = diff_wide[7:0]; // RULE3 RULE4
        end else if (acc_load_en) begin
            nxt_acc = acc_load_data;
        end
    end

    // Accumulator register; rotate and accumulator subtracts win over an external load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff <= rcs_pkg::ACC_RST;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // Memory write-back; the rotate never writes memory
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_wr_en_ff   <= 1'b0;
            mem_wr_data_ff <= rcs_pkg::MEM_RST;
        end else begin
            mem_wr_en_ff <= is_sub_to_mem; // RULE5 RULE2
            if (is_sub_to_mem) begin
                mem_wr_data_ff <= diff_wide[7:0]; // RULE5
            end
        end
    end

    // Carry flag: rotate, subtract, or external load in that order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            carry_flag_ff <= rcs_pkg::FLAG_RST;
        end else if (is_rotate) begin
            carry_flag_ff <= mem_operand[0]; // RULE1
        end else if (is_sub) begin
            carry_flag_ff <= nxt_carry; // RULE6
        end else if (carry_load_en) begin
            carry_flag_ff <= carry_load_value;
        end
    end

    // Remaining arithmetic flags; the rotate leaves them alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_flag_ff     <= rcs_pkg::FLAG_RST;
            zero_flag_ff         <= rcs_pkg::FLAG_RST;
            aux_carry_flag_ff    <= rcs_pkg::FLAG_RST;
            signed_carry_flag_ff <= rcs_pkg::FLAG_RST;
            carry_zero_flag_ff   <= rcs_pkg::FLAG_RST;
        end else if (is_sub) begin
            overflow_flag_ff     <= nxt_overflow; // RULE7
            zero_flag_ff         <= nxt_zero; // RULE7
            aux_carry_flag_ff    <= nxt_aux_carry; // RULE7
            signed_carry_flag_ff <= nxt_signed_carry; // RULE7
            carry_zero_flag_ff   <= nxt_carry_zero; // RULE7
        end else if (carry_load_en && !op_valid) begin
            // A carry load from the core opens a new multi-byte chain; without it the chain stays low
            carry_zero_flag_ff   <= 1'b1; // RULE7
        end
    end

    // Checks on the datapath

    rotate_acc_value_a: assert property ( // RULE1
        @(posedge clk) disable iff (rst)
        is_rotate |=> acc_ff == {$past(carry_flag_ff), $past(mem_operand[7:1])})
        else $error("rotate result wrong");

    rotate_carry_out_a: assert property ( // RULE1
        @(posedge clk) disable iff (rst)
        is_rotate |=> carry_flag_ff == $past(mem_operand[0]))
        else $error("rotate carry wrong");

    rotate_flags_kept_a: assert property ( // RULE1
        @(posedge clk) disable iff (rst)
        is_rotate |=> $stable(overflow_flag_ff) && $stable(zero_flag_ff) && $stable(aux_carry_flag_ff) &&
        $stable(signed_carry_flag_ff) && $stable(carry_zero_flag_ff))
        else $error("rotate changed other flags");

    carry_chain_restart_a: assert property ( // RULE7
        @(posedge clk) disable iff (rst)
        (carry_load_en && !op_valid) |=> carry_zero_flag_ff)
        else $error("carry load did not restart zero chain");

    rotate_no_mem_a: assert property ( // RULE2
        @(posedge clk) disable iff (rst)
        is_rotate |=> !mem_wr_en_ff)
        else $error("rotate wrote memory");

    sub_mem_acc_a: assert property ( // RULE3
        @(posedge clk) disable iff (rst)
        (op_valid && op_code == rcs_pkg::RCS_OP_SUBTRACT_WITH_BORROW_MEM) |=>
        acc_ff == 8'($past(acc_ff) - $past(mem_operand) - {7'h00, ~$past(carry_flag_ff)}))
        else $error("memory subtract result wrong");

    sub_imm_acc_a: assert property ( // RULE4
        @(posedge clk) disable iff (rst)
        (op_valid && op_code == rcs_pkg::RCS_OP_SUBTRACT_WITH_BORROW_IMM) |=>
        acc_ff == 8'($past(acc_ff) - $past(imm_operand) - {7'h00, ~$past(carry_flag_ff)}))
        else $error("immediate subtract result wrong");

    sub_to_mem_a: assert property ( // RULE5
        @(posedge clk) disable iff (rst)
        is_sub_to_mem |=> mem_wr_en_ff && (acc_ff == ($past(acc_load_en) ? $past(acc_load_data) : $past(acc_ff))) &&
        (mem_wr_data_ff == 8'($past(acc_ff) - $past(mem_operand) - {7'h00, ~$past(carry_flag_ff)}))
        ##1 (!mem_wr_en_ff || $past(is_sub_to_mem)))
        else $error("to-memory subtract wrong");

    sub_carry_sign_a: assert property ( // RULE6
        @(posedge clk) disable iff (rst)
        is_sub |=> carry_flag_ff == ({1'b0, $past(acc_ff)} >= ({1'b0, $past(sub_operand)} + {8'h00, ~$past(carry_flag_ff)})))
        else $error("subtract carry wrong");

    sub_zero_flag_a: assert property ( // RULE8
        @(posedge clk) disable iff (rst)
        is_sub |=> zero_flag_ff == ($past(chk_diff_ext[7:0]) == 8'h00) &&
        carry_zero_flag_ff == (zero_flag_ff && $past(carry_zero_flag_ff)))
        else $error("zero flags wrong");

    sub_overflow_a: assert property ( // RULE8
        @(posedge clk) disable iff (rst)
        is_sub |=> overflow_flag_ff == (($past(chk_diff_ext[9:7]) != 3'b000) && ($past(chk_diff_ext[9:7]) != 3'b111)))
        else $error("overflow flag wrong");

    sub_aux_signed_a: assert property ( // RULE7
        @(posedge clk) disable iff (rst)
        is_sub |=> aux_carry_flag_ff == ({1'b0, $past(acc_ff[3:0])} >=
        ({1'b0, $past(sub_operand[3:0])} + {4'h0, ~$past(carry_flag_ff)})) &&
        signed_carry_flag_ff == $past(chk_diff_ext[9]))
        else $error("aux or signed carry wrong");

endmodule

// ---- testbench/rcs_alu_bench.sv ----
// Self-checking bench for the rotate and subtract-with-borrow datapath
`timescale 1ns/100ps

module rcs_alu_bench;
    // Short aliases for the four instructions
    localparam rcs_pkg::rcs_op_t OP_ROT = rcs_pkg::RCS_OP_ROTATE_RIGHT_CARRY_TO_ACC;
    localparam rcs_pkg::rcs_op_t OP_SBM = rcs_pkg::RCS_OP_SUBTRACT_WITH_BORROW_MEM;
    localparam rcs_pkg::rcs_op_t OP_SBI = rcs_pkg::RCS_OP_SUBTRACT_WITH_BORROW_IMM;
    localparam rcs_pkg::rcs_op_t OP_SBT = rcs_pkg::RCS_OP_SUBTRACT_WITH_BORROW_TO_MEM;
    // Design inputs
    logic             clk, rst, op_valid, acc_load_en, carry_load_en, carry_load_value;
    rcs_pkg::rcs_op_t op_code;
    logic [7:0]       mem_operand, imm_operand, acc_load_data;
    // Design outputs
    logic [7:0]       acc_ff, mem_wr_data_ff;
    logic             mem_wr_en_ff, carry_flag_ff, overflow_flag_ff, zero_flag_ff;
    logic             aux_carry_flag_ff, signed_carry_flag_ff, carry_zero_flag_ff;
    // Reference model state and scratch
    logic [7:0]       e_acc, e_wd, x;
    logic             e_c, e_ov, e_z, e_ac, e_sc, e_cz, e_we;
    logic [8:0]       d9;
    logic [4:0]       d5;
    int               num_errors = 0;
    int               tests_run  = 0;

    rcs_alu rcs_alu_inst (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .mem_operand(mem_operand), .imm_operand(imm_operand), .acc_load_en(acc_load_en),
        .acc_load_data(acc_load_data), .carry_load_en(carry_load_en), .carry_load_value(carry_load_value),
        .acc_ff(acc_ff), .mem_wr_en_ff(mem_wr_en_ff), .mem_wr_data_ff(mem_wr_data_ff),
        .carry_flag_ff(carry_flag_ff), .overflow_flag_ff(overflow_flag_ff), .zero_flag_ff(zero_flag_ff),
        .aux_carry_flag_ff(aux_carry_flag_ff), .signed_carry_flag_ff(signed_carry_flag_ff),
        .carry_zero_flag_ff(carry_zero_flag_ff));

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Model difference of the operands now on the ports
    always_comb begin
        x  = (op_code == OP_SBI) ? imm_operand : mem_operand;
        d9 = {1'b0, e_acc} - {1'b0, x} - {8'h00, ~e_c};
        d5 = {1'b0, e_acc[3:0]} - {1'b0, x[3:0]} - {4'h0, ~e_c};
    end

    // Reference model; samples the same edge as the design, instructions win over loads
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {e_acc, e_wd} <= 16'h0000;
            {e_c, e_ov, e_z, e_ac, e_sc, e_cz, e_we} <= 7'h00;
        end else begin
            e_we <= 1'b0;
            if (acc_load_en && !(op_valid && op_code != OP_SBT)) e_acc <= acc_load_data;
            if (carry_load_en && !op_valid) e_c <= carry_load_value;
            if (carry_load_en && !op_valid) e_cz <= 1'b1;
            if (op_valid && op_code == OP_ROT) begin
                e_acc <= {e_c, mem_operand[7:1]};
                e_c   <= mem_operand[0];
            end else if (op_valid) begin
                e_c  <= ~d9[8];
                e_ac <= ~d5[4];
                e_ov <= (e_acc[7] ^ x[7]) & (d9[7] ^ e_acc[7]);
                e_z  <= d9[7:0] == 8'h00;
                e_sc <= ((e_acc[7] ^ x[7]) & (d9[7] ^ e_acc[7])) ^ d9[7];
                e_cz <= (d9[7:0] == 8'h00) & e_cz;
                if (op_code == OP_SBT) begin
                    e_we <= 1'b1;
                    e_wd <= d9[7:0];
                end else e_acc <= d9[7:0];
            end
        end
    end

    // Compare one value; every call is counted
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Every settled cycle out of reset is held against the model
    always @(negedge clk) begin
        if (!rst) begin
            check(acc_ff, e_acc, "accumulator");
            check(mem_wr_data_ff, e_wd, "memory data");
            check({7'h00, mem_wr_en_ff}, {7'h00, e_we}, "memory write");
            check({2'b00, carry_flag_ff, overflow_flag_ff, zero_flag_ff, aux_carry_flag_ff, signed_carry_flag_ff,
                carry_zero_flag_ff}, {2'b00, e_c, e_ov, e_z, e_ac, e_sc, e_cz}, "flags");
        end
    end

    // One cycle of stimulus, launched at the rising edge
    task automatic drv(input logic v, input rcs_pkg::rcs_op_t op, input logic [7:0] m, input logic [7:0] im,
                       input logic ae, input logic [7:0] ad, input logic ce, input logic cv);
        @(posedge clk);
        op_valid         <= v;
        op_code          <= op;
        mem_operand      <= m;
        imm_operand      <= im;
        acc_load_en      <= ae;
        acc_load_data    <= ad;
        carry_load_en    <= ce;
        carry_load_value <= cv;
    endtask

    // Back-to-back rotates; the second ignores loads in its own cycle
    task automatic rot_scn();
        drv(1'b0, OP_ROT, 8'h00, 8'h00, 1'b1, 8'h5a, 1'b1, 1'b1);
        drv(1'b1, OP_ROT, 8'h81, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        drv(1'b1, OP_ROT, 8'h02, 8'h00, 1'b1, 8'h33, 1'b1, 1'b1);
        drv(1'b0, OP_ROT, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        @(negedge clk);
        check(acc_ff, 8'h81, "rotate result");
        check({7'h00, carry_flag_ff}, 8'h00, "rotate carry");
    endtask

    // Zero difference, then a borrow that wraps below zero
    task automatic sbm_scn();
        drv(1'b0, OP_SBM, 8'h00, 8'h00, 1'b1, 8'h10, 1'b1, 1'b1);
        drv(1'b1, OP_SBM, 8'h10, 8'h99, 1'b0, 8'h00, 1'b0, 1'b0);
        drv(1'b1, OP_SBM, 8'h01, 8'h99, 1'b0, 8'h00, 1'b0, 1'b0);
        drv(1'b0, OP_SBM, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        @(negedge clk);
        check(acc_ff, 8'hff, "memory subtract");
        check({7'h00, carry_flag_ff}, 8'h00, "negative carry");
    endtask

    // Immediate operand with signed overflow; memory bus carries a decoy
    task automatic sbi_scn();
        drv(1'b0, OP_SBI, 8'h00, 8'h00, 1'b1, 8'h80, 1'b1, 1'b0);
        drv(1'b1, OP_SBI, 8'h55, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0);
        drv(1'b0, OP_SBI, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        @(negedge clk);
        check(acc_ff, 8'h7e, "immediate subtract");
        check({7'h00, overflow_flag_ff}, 8'h01, "overflow");
    endtask

    // Two writes to memory back to back; accumulator load in the same cycle still lands
    task automatic sbt_scn();
        drv(1'b0, OP_SBT, 8'h00, 8'h00, 1'b1, 8'h05, 1'b1, 1'b1);
        drv(1'b1, OP_SBT, 8'h03, 8'h00, 1'b1, 8'h77, 1'b1, 1'b0);
        drv(1'b1, OP_SBT, 8'h02, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        drv(1'b0, OP_SBT, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        @(negedge clk);
        check(mem_wr_data_ff, 8'h75, "memory difference");
        check(acc_ff, 8'h77, "accumulator kept");
    endtask

    // All codes mixed without gaps
    task automatic sweep_scn();
        for (int i = 0; i < 24; i++) begin
            drv(1'b1, rcs_pkg::rcs_op_t'(2'(i * 3)), 8'(i * 37), 8'(i * 91), 1'b0, 8'h00, 1'b0, 1'b0);
        end
        drv(1'b0, OP_ROT, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        @(negedge clk);
        check({7'h00, mem_wr_en_ff}, 8'h00, "write idle");
    endtask

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        {op_valid, acc_load_en, carry_load_en, carry_load_value} = 4'h0;
        {mem_operand, imm_operand, acc_load_data} = 24'h000000;
        op_code = OP_ROT;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rot_scn();
        sbm_scn();
        sbi_scn();
        sbt_scn();
        sweep_scn();
        print_verdict();
    end

    // Watchdog, far beyond the roughly 60 cycles the run needs
    initial begin
        #20000;
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
